// >>> design/spi_port.sv
// Byte-wide serial port, master or slave, with APB register access
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`include "spi_port_defs.svh"

// Functional notes
// [R1] Write during shifting sets sticky write collision
// [R2] Slave byte into full buffer: overflow, byte lost
// [R3] Master mode never sets receive overflow
// [R4] Enable hands pins to port, else GPIO
// [R5] Idle clock level follows clock idle bit
// [R6] Master codes 0-3 select four clock rates
// [R7] Codes 4 and 5 select slave modes
// [R8] Other mode codes are not SPI configurations
// [R9] Shift eight bits, MSb first, both directions
// [R10] Eighth bit: load buffer, set full, flag
// [R11] Receive path double-buffered behind shifter
// [R12] Colliding buffer write is dropped entirely
// [R13] Buffer read clears buffer full
// [R14] Software reads buffer after every transfer
// [R15] Reconfigure only with port disabled
// [R16] Software sets pin directions per mode
// [R17] Launch on one edge, capture on other
// [R18] Master write starts clock immediately
// [R19] Master with output off still receives
// [R20] Edge select one: data before first edge
// [R21] Slave shifts on external clock, flags
// [R22] Slave byte completion raises wake event
// [R23] Sample phase picks middle or end capture; slave modes ignore it and always capture mid-bit
// [R24] Edge select picks launch clock transition
// [R25] Select high or disable: float, counter zero
module spi_port (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE,
  input wire logic SDI_I,
  output logic SDO_O,
  output logic SDO_OE,
  input wire logic SS_N_I,
  input wire logic GPIO_SCK_O,
  input wire logic GPIO_SCK_OE,
  input wire logic GPIO_SDO_O,
  input wire logic GPIO_SDO_OE,
  input wire logic SDO_DIR_OUT,
  input wire logic TIMER_TICK,
  output logic PORT_FLAG,
  output logic WAKE_EVENT
);
  import spi_port_pkg::*;

  function automatic port_kind_e mode_kind(input logic [3:0] m);
    unique case (m)
      `MODE_M4, `MODE_M16, `MODE_M64, `MODE_MTMR: mode_kind = KIND_MASTER; // [R6]
      `MODE_SL_SS: mode_kind = KIND_SLAVE_SS; // [R7]
      `MODE_SL_FREE: mode_kind = KIND_SLAVE_FREE; // [R7]
      default: mode_kind = KIND_OFF; // [R8]
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic acc, wr, rd, hit_buf, hit_ctrl, hit_stat, hit_evt, mapped;
  logic buf_wr, buf_rd;

  assign acc = PSEL && PENABLE;
  assign wr = acc && PWRITE;
  assign rd = acc && !PWRITE;
  assign hit_buf = (PADDR == `OFS_BUF);
  assign hit_ctrl = (PADDR == `OFS_CTRL);
  assign hit_stat = (PADDR == `OFS_STAT);
  assign hit_evt = (PADDR == `OFS_EVT);
  assign mapped = hit_buf || hit_ctrl || hit_stat || hit_evt;
  assign buf_wr = wr && hit_buf;
  assign buf_rd = rd && hit_buf;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration

  logic port_enable, clock_idle_level, input_sample_phase, edge_sel;
  logic [3:0] port_mode_field;
  logic next_port_enable, next_clock_idle_level, next_input_sample_phase, next_edge_sel;
  logic [3:0] next_port_mode_field;

  always_comb begin
    next_port_enable = port_enable;
    next_clock_idle_level = clock_idle_level;
    next_port_mode_field = port_mode_field;
    next_input_sample_phase = input_sample_phase;
    next_edge_sel = edge_sel;
    if (wr && hit_ctrl) begin
      next_port_enable = PWDATA[`CTL_EN];
      next_clock_idle_level = PWDATA[`CTL_CKP];
      next_port_mode_field = PWDATA[3:0];
    end
    if (wr && hit_stat) begin
      next_input_sample_phase = PWDATA[`STA_SMP];
      next_edge_sel = PWDATA[`STA_CKE];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      port_enable <= 1'((`CTRL_RST >> `CTL_EN));
      clock_idle_level <= 1'b0;
      port_mode_field <= 4'h0;
      input_sample_phase <= 1'b0;
      edge_sel <= 1'b0;
    end else begin
      port_enable <= next_port_enable;
      clock_idle_level <= next_clock_idle_level;
      port_mode_field <= next_port_mode_field;
      input_sample_phase <= next_input_sample_phase;
      edge_sel <= next_edge_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and rate generator

  logic sck_s, sdi_s, ss_act_s, half_tick;
  port_kind_e kind;
  logic is_master, is_slave, slave_ss, slave_on, busy;
  xfer_state_e st, next_st;

  // Select is inverted before the first stage so reset means deselected
  sync2 u_sync (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .d({SCK_I, SDI_I, !SS_N_I}),
    .q({sck_s, sdi_s, ss_act_s})
  );

  rate_tick u_rate (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .run(st == ST_SHIFT),
    .rate(port_mode_field[1:0]),
    .timer_tick(TIMER_TICK),
    .half_tick(half_tick)
  );

  assign kind = port_enable ? mode_kind(port_mode_field) : KIND_OFF;
  assign is_master = (kind == KIND_MASTER);
  assign is_slave = (kind == KIND_SLAVE_SS) || (kind == KIND_SLAVE_FREE);
  assign slave_ss = (kind == KIND_SLAVE_SS);
  assign slave_on = (kind == KIND_SLAVE_FREE) || (slave_ss && ss_act_s);

  ////////////////////////////////////////////////////////////////////////////
  // Shift engine, buffer and status

  logic [4:0] half, next_half;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] tx, next_tx, rx, next_rx, xbuf, next_xbuf, rx_fin;
  logic out_bit, next_out_bit, sck_lvl, next_sck_lvl, sck_prev;
  logic bf, next_bf, write_collision_flag, next_write_collision_flag, ovf, next_ovf, pflag, next_pflag;
  logic wake, next_wake, done, lead, trail, cap, launch;
  logic [1:0] cap_d, next_cap_d, end_d, next_end_d;
  logic m_cap, m_end;
  logic [7:0] rx_new;

  assign busy = (st == ST_SHIFT) || (bit_cnt != 3'h0) || (end_d != 2'b00);
  assign lead = (sck_s != sck_prev) && (sck_s != clock_idle_level);
  assign trail = (sck_s != sck_prev) && (sck_s == clock_idle_level);

  always_comb begin
    next_st = st;
    next_half = half;
    next_bit_cnt = bit_cnt;
    next_tx = tx;
    next_rx = rx;
    next_xbuf = xbuf;
    next_out_bit = out_bit;
    next_sck_lvl = sck_lvl;
    next_bf = bf;
    next_write_collision_flag = write_collision_flag;
    next_ovf = ovf;
    next_pflag = pflag;
    next_wake = 1'b0;
    done = 1'b0;
    cap = 1'b0;
    launch = 1'b0;
    m_cap = 1'b0;
    m_end = 1'b0;
    next_cap_d = 2'b00;
    next_end_d = 2'b00;
    rx_fin = {rx[6:0], sdi_s};
    rx_new = rx;
    if (wr && hit_ctrl) begin
      next_write_collision_flag = PWDATA[`CTL_WRITE_COLLISION_FLAG];
      next_ovf = PWDATA[`CTL_OVF];
    end
    if (wr && hit_evt && PWDATA[`EVT_FLAG]) begin
      next_pflag = 1'b0;
    end
    if (buf_rd) begin
      next_bf = 1'b0; // [R13]
    end
    if (kind == KIND_OFF) begin
      // Disable aborts any transfer and clears the bit position
      next_st = ST_IDLE; // [R25] [R8]
      next_half = 5'h00;
      next_bit_cnt = 3'h0; // [R25]
      next_sck_lvl = clock_idle_level;
    end else begin
      if (buf_wr) begin
        if (busy) begin
          next_write_collision_flag = 1'b1; // [R1] [R12]
        end else begin
          next_xbuf = PWDATA[7:0];
          next_tx = edge_sel ? {PWDATA[6:0], 1'b0} : PWDATA[7:0];
          next_out_bit = PWDATA[7]; // [R20]
          next_rx = 8'h00;
          if (is_master) begin
            next_st = ST_SHIFT; // [R18]
            next_half = 5'h00;
          end
        end
      end
      if (is_master) begin
        if (st == ST_IDLE) begin
          next_sck_lvl = clock_idle_level; // [R5]
        end else if (half_tick) begin
          launch = (half != `HALF_LAST) && !(half[0] ^ edge_sel); // [R24] [R17]
          if (input_sample_phase) begin
            m_cap = (half != 5'h00) && !(half[0] ^ edge_sel); // [R23]
          end else begin
            m_cap = (half != `HALF_LAST) && (half[0] ^ edge_sel); // [R23]
          end
          if (half != `HALF_LAST) begin
            next_sck_lvl = !sck_lvl;
            next_half = 5'(half + 5'h01);
          end else begin
            m_end = 1'b1; // [R9]
            next_st = ST_IDLE;
            next_half = 5'h00;
          end
        end
        // The synchronised input lags the pin by two clocks, so capture and
        // completion trail the clock edges by the same two clocks
        next_cap_d = {cap_d[0], m_cap};
        next_end_d = {end_d[0], m_end};
        cap = cap_d[1]; // [R23] [R19]
        done = end_d[1]; // [R9]
      end else if (is_slave) begin
        if (!slave_on) begin
          next_bit_cnt = 3'h0; // [R25]
        end else begin
          // Sample phase is ignored here: slave always captures mid-bit
          launch = edge_sel ? trail : lead; // [R24] [R17] [R23]
          cap = edge_sel ? lead : trail; // [R21] [R17]
          if (cap) begin
            next_bit_cnt = 3'(bit_cnt + 3'h1);
            if (bit_cnt == `BIT_LAST) begin
              done = 1'b1; // [R21] [R9]
              next_bit_cnt = 3'h0;
              next_wake = 1'b1; // [R22]
            end
          end
        end
      end
      if (launch) begin
        next_out_bit = tx[7]; // [R9]
        next_tx = {tx[6:0], 1'b0};
      end
      rx_new = cap ? rx_fin : rx;
      if (cap) begin
        next_rx = rx_fin; // [R9] [R19]
      end
      if (done) begin
        next_pflag = 1'b1; // [R10] [R21]
        if (is_slave && bf && !buf_rd) begin
          next_ovf = 1'b1; // [R2]
        end else begin
          next_xbuf = rx_new; // [R10] [R11] [R3]
          next_bf = 1'b1; // [R10]
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= ST_IDLE;
      half <= 5'h00;
      bit_cnt <= 3'h0;
      tx <= 8'h00;
      rx <= 8'h00;
      xbuf <= 8'h00;
      out_bit <= 1'b0;
      sck_lvl <= 1'b0;
      sck_prev <= 1'b0;
      bf <= 1'b0;
      write_collision_flag <= 1'b0;
      ovf <= 1'b0;
      pflag <= 1'b0;
      wake <= 1'b0;
      cap_d <= 2'b00;
      end_d <= 2'b00;
    end else begin
      st <= next_st;
      half <= next_half;
      bit_cnt <= next_bit_cnt;
      tx <= next_tx;
      rx <= next_rx;
      xbuf <= next_xbuf;
      out_bit <= next_out_bit;
      sck_lvl <= next_sck_lvl;
      sck_prev <= sck_s;
      bf <= next_bf;
      write_collision_flag <= next_write_collision_flag;
      ovf <= next_ovf;
      pflag <= next_pflag;
      wake <= next_wake;
      cap_d <= next_cap_d;
      end_d <= next_end_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data is captured in the setup cycle so the access cycle can end at once

  logic [31:0] rdata, next_rdata;
  logic perr, next_perr;

  always_comb begin
    next_rdata = rdata;
    next_perr = perr;
    if (PSEL && !PENABLE) begin
      next_perr = !mapped;
      next_rdata = 32'h0000_0000;
      if (hit_buf) next_rdata = {24'h00_0000, xbuf};
      if (hit_ctrl) next_rdata = {24'h00_0000, write_collision_flag, ovf, port_enable, clock_idle_level,
                                  port_mode_field};
      if (hit_stat) next_rdata = {24'h00_0000, input_sample_phase, edge_sel, 5'h00, bf};
      if (hit_evt) next_rdata = {31'h0000_0000, pflag};
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata <= 32'h0000_0000;
      perr <= 1'b0;
    end else begin
      rdata <= next_rdata;
      perr <= next_perr;
    end
  end

  assign PRDATA = rdata;
  assign PSLVERR = perr && acc;
  assign PREADY = PENABLE;

  ////////////////////////////////////////////////////////////////////////////
  // Pins: with the port off, the general I/O drivers own them

  assign SCK_O = port_enable ? sck_lvl : GPIO_SCK_O; // [R4]
  assign SCK_OE = port_enable ? is_master : GPIO_SCK_OE; // [R4]
  assign SDO_O = port_enable ? out_bit : GPIO_SDO_O; // [R4]
  // Slave with select control floats the data line while deselected
  assign SDO_OE = port_enable ? (SDO_DIR_OUT && (is_master || (kind == KIND_SLAVE_FREE)
                  || (slave_ss && ss_act_s))) : GPIO_SDO_OE; // [R25] [R19] [R4]
  assign PORT_FLAG = pflag;
  assign WAKE_EVENT = wake;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  a_write_collision_flag_set: assert property (buf_wr && busy && kind != KIND_OFF
    |=> write_collision_flag && tx == $past(launch ? {tx[6:0], 1'b0} : tx)) // [R12]
    else $error("collision write not flagged or not dropped");
  a_write_collision_flag_hold: assert property (write_collision_flag && !(wr && hit_ctrl) |=> write_collision_flag) // [R1]
    else $error("write collision flag lost");
  a_ovf_master: assert property (is_master && !(wr && hit_ctrl) |=> !$rose(ovf)) // [R3]
    else $error("overflow raised in master mode");
  a_ovf_slave: assert property (done && is_slave && bf && !buf_rd |=> ovf && $stable(xbuf)) // [R2]
    else $error("slave overflow not flagged or buffer overwritten");
  a_load_buf: assert property (done && !(is_slave && bf && !buf_rd)
    |=> bf && pflag && xbuf == $past(rx_new)) // [R10]
    else $error("completed byte not loaded");
  a_bf_clear: assert property (buf_rd && !done |=> !bf) // [R13]
    else $error("buffer read did not clear full");
  a_sck_idle: assert property (is_master && st == ST_IDLE && $stable(clock_idle_level)
    && $stable(port_enable) |-> SCK_O == clock_idle_level) // [R5]
    else $error("master clock not at idle level");
  a_first_bit: assert property (buf_wr && is_master && !busy
    |=> st == ST_SHIFT && SDO_O == $past(PWDATA[7])) // [R20]
    else $error("transfer not started with msb presented");
  a_fast_span: assert property ($rose(st == ST_SHIFT) && port_mode_field == `MODE_M4
    && port_enable |-> ##33 st == ST_SHIFT ##1 st == ST_IDLE) // [R9]
    else $error("fastest master byte not 34 cycles");
  a_ss_float: assert property (slave_ss && !ss_act_s |-> !SDO_OE ##1 bit_cnt == 3'h0) // [R25]
    else $error("deselected slave drives or keeps count");
  a_wake: assert property (done && is_slave |=> WAKE_EVENT ##1 !WAKE_EVENT) // [R22]
    else $error("slave completion gave no wake pulse");

  c_master_done: cover property (done && is_master);
  c_slave_done: cover property (done && is_slave);
  c_overflow: cover property ($rose(ovf));
  c_collision: cover property ($rose(write_collision_flag));
endmodule

// >>> design/spi_port_defs.svh
// Offsets, field positions, reset values and rate counts of the serial port
`ifndef SPI_PORT_DEFS_SVH
`define SPI_PORT_DEFS_SVH

`define OFS_BUF 8'h10
`define OFS_CTRL 8'h14
`define OFS_EVT 8'h1C
`define OFS_STAT 8'h94

`define CTL_WRITE_COLLISION_FLAG 7
`define CTL_OVF 6
`define CTL_EN 5
`define CTL_CKP 4
`define STA_SMP 7
`define STA_CKE 6
`define STA_BF 0
`define EVT_FLAG 0

`define CTRL_RST 8'h00
`define STAT_RST 8'h00

`define MODE_M4 4'h0
`define MODE_M16 4'h1
`define MODE_M64 4'h2
`define MODE_MTMR 4'h3
`define MODE_SL_SS 4'h4
`define MODE_SL_FREE 4'h5

`define HALF_M4 6'h02
`define HALF_M16 6'h08
`define HALF_M64 6'h20
`define HALF_LAST 5'h10
`define BIT_LAST 3'h7

`endif

// >>> design/spi_port_pkg.sv
// Types shared by the serial port modules
package spi_port_pkg;
  typedef enum logic [1:0] {KIND_OFF, KIND_MASTER, KIND_SLAVE_SS, KIND_SLAVE_FREE} port_kind_e;
  typedef enum logic {ST_IDLE, ST_SHIFT} xfer_state_e;
endpackage

// >>> design/sync2.sv
// Two-stage synchroniser for the serial port input pins
`timescale 1ns/1ns
module sync2 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] d,
  output logic [2:0] q
);
  logic [2:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 3'h0;
      q <= 3'h0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// >>> design/rate_tick.sv
// Half-period tick generator for the master serial clock
`timescale 1ns/1ns
`include "spi_port_defs.svh"
module rate_tick (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [1:0] rate,
  input wire logic timer_tick,
  output logic half_tick
);
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [5:0] half_len;
  logic div_tick;

  always_comb begin
    unique case (rate)
      2'h0: half_len = `HALF_M4; // [R6]
      2'h1: half_len = `HALF_M16; // [R6]
      2'h2: half_len = `HALF_M64; // [R6]
      2'h3: half_len = `HALF_M64;
    endcase
    div_tick = (cnt == 6'(half_len - 6'h01));
    next_cnt = cnt;
    if (!run || div_tick) begin
      next_cnt = 6'h00;
    end else begin
      next_cnt = 6'(cnt + 6'h01);
    end
    // Timer output divided by two: each timer pulse is one half period
    half_tick = run && ((rate == 2'h3) ? timer_tick : div_tick); // [R6]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 6'h00;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule

// >>> bench/spi_partner.sv
// Far-side serial device: a slave that answers the port, or a master that clocks it
`timescale 1ns/1ns
module spi_partner (
  input wire logic clk,
  input wire logic sck,
  input wire logic sel_n,
  input wire logic din,
  output logic dout,
  output logic sck_drv
);
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic [7:0] sh;
  logic junk;
  initial begin
    tx_byte = 8'h00;
    rx_byte = 8'h00;
    sh = 8'h00;
    sck_drv = 1'b0;
    junk = 1'b0;
  end
  // A deselected output wanders so that a stale bit never passes for data
  always @(posedge clk) junk <= ~junk;
  always @(negedge sel_n) sh = tx_byte;
  always @(posedge sck) if (!sel_n) rx_byte <= {rx_byte[6:0], din};
  always @(negedge sck) if (!sel_n) sh <= {sh[6:0], 1'b0};
  assign dout = sel_n ? junk : sh[7];
  ////////////////////////////////////////////////////////////////////////////////
  // Master role: idle-low clock, six system clocks a level, still between bytes
  task automatic drive_byte();
    for (int i = 0; i < 8; i++) begin
      repeat (6) @(posedge clk);
      sck_drv <= 1'b1;
      repeat (6) @(posedge clk);
      sck_drv <= 1'b0;
    end
  endtask
endmodule

// >>> bench/spi_port_tb.sv
// Self-checking bench for the serial port: registers, master rates, slave traffic
`timescale 1ns/1ns
`include "spi_port_defs.svh"
module spi_port_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, sck_o, sck_oe, sdo_o, sdo_oe, port_flag, wake_event;
  logic sck_pin, sdo_pin, sdi_pin, sck_drv, err;
  logic sel_n = 1'b1;
  logic [3:0] gpio = 4'hA;
  logic sdo_dir = 1'b1;
  logic tick = 1'b0;
  logic sdo_float = 1'b0;
  logic [31:0] rd;
  int errors = 0;
  int cmp_count = 0;
  int wakes = 0;
  int tcnt = 0;

  always #25 sys_clk = ~sys_clk;
  // Timer pulse every six clocks; a released data pin toggles instead of holding
  always @(posedge sys_clk) begin
    sdo_float <= ~sdo_float;
    tcnt <= (tcnt == 5) ? 0 : tcnt + 1;
    tick <= (tcnt == 5);
    if (wake_event === 1'b1) wakes <= wakes + 1;
  end
  assign sck_pin = sck_oe ? sck_o : sck_drv;
  assign sdo_pin = sdo_oe ? sdo_o : sdo_float;

  spi_port dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SCK_I(sck_pin), .SCK_O(sck_o), .SCK_OE(sck_oe), .SDI_I(sdi_pin),
    .SDO_O(sdo_o), .SDO_OE(sdo_oe), .SS_N_I(sel_n), .GPIO_SCK_O(gpio[0]),
    .GPIO_SCK_OE(gpio[1]), .GPIO_SDO_O(gpio[2]), .GPIO_SDO_OE(gpio[3]),
    .SDO_DIR_OUT(sdo_dir), .TIMER_TICK(tick), .PORT_FLAG(port_flag),
    .WAKE_EVENT(wake_event));
  spi_partner peer (.clk(sys_clk), .sck(sck_pin), .sel_n(sel_n), .din(sdo_pin),
    .dout(sdi_pin), .sck_drv(sck_drv));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h000000, exp}, rd);
  endtask

  task automatic wait_flag();
    int n;
    n = 0;
    while (port_flag !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    chk("port flag", 1, port_flag);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdc("control reset", `OFS_CTRL, `CTRL_RST);
    rdc("status reset", `OFS_STAT, `STAT_RST);
    apb(1'b0, 8'h40, 8'h00);
    chk("unmapped error", 1, err);
    chk("gpio pins A", gpio, {sdo_oe, sdo_o, sck_oe, sck_o});
    gpio <= 4'h5;
    repeat (2) @(posedge sys_clk);
    chk("gpio pins 5", 4'h5, {sdo_oe, sdo_o, sck_oe, sck_o});
    wr(`OFS_CTRL, 8'h30);
    repeat (3) @(posedge sys_clk);
    chk("idle clock high", 2'b11, {sck_oe, sck_o});
    wr(`OFS_CTRL, 8'h00);
    wr(`OFS_CTRL, 8'h26);
    wr(`OFS_BUF, 8'h55);
    repeat (40) @(posedge sys_clk);
    chk("reserved mode idle", 2'b00, {sck_oe, port_flag});
    wr(`OFS_CTRL, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_master();
    wr(`OFS_STAT, 8'h40);
    peer.tx_byte = 8'h3C;
    sel_n <= 1'b0;
    wr(`OFS_CTRL, 8'h20);
    wr(`OFS_BUF, 8'hA5);
    @(posedge sys_clk);
    #1;
    chk("first bit early", 2'b10, {sdo_o, sck_o});
    wr(`OFS_BUF, 8'h0F);
    wait_flag();
    chk("peer received", 8'hA5, peer.rx_byte);
    rdc("buffer full", `OFS_STAT, 8'h41);
    rdc("received byte", `OFS_BUF, 8'h3C);
    rdc("full cleared", `OFS_STAT, 8'h40);
    rdc("collision set", `OFS_CTRL, 8'hA0);
    wr(`OFS_CTRL, 8'h20);
    rdc("collision cleared", `OFS_CTRL, 8'h20);
    wr(`OFS_EVT, 8'h01);
    @(posedge sys_clk);
    chk("flag cleared", 0, port_flag);
    sel_n <= 1'b1;
    $display("test master done");
  endtask

  // Timer mode also runs with the data-out pin turned to input
  task automatic t_rates();
    int half[4] = '{`HALF_M4, `HALF_M16, `HALF_M64, 6};
    logic s0;
    int n;
    for (int m = 0; m < 4; m++) begin
      @(posedge sys_clk);
      sdo_dir <= (m != 3);
      peer.tx_byte = 8'h5C + m[7:0];
      sel_n <= 1'b0;
      wr(`OFS_CTRL, 8'h00);
      wr(`OFS_STAT, (m == 1) ? 8'hC0 : ((m == 2) ? 8'h00 : 8'h40));
      wr(`OFS_CTRL, 8'h20 | m[7:0]);
      wr(`OFS_BUF, 8'h96);
      for (int k = 0; k < 2; k++) begin
        s0 = sck_o;
        n = 0;
        while (sck_o === s0 && n < 100) begin
          @(posedge sys_clk);
          n++;
        end
      end
      chk("half period", half[m], n);
      wait_flag();
      rdc("rate byte", `OFS_BUF, 8'h5C + m[7:0]);
      chk("data out enable", (m == 3) ? 0 : 1, sdo_oe);
      wr(`OFS_EVT, 8'h01);
      sel_n <= 1'b1;
    end
    sdo_dir <= 1'b1;
    $display("test rates done");
  endtask

  task automatic t_slave();
    wr(`OFS_CTRL, 8'h00);
    wr(`OFS_CTRL, 8'h24);
    wr(`OFS_BUF, 8'hC3);
    peer.tx_byte = 8'h5A;
    sel_n <= 1'b0;
    peer.drive_byte();
    wait_flag();
    chk("slave sent", 8'hC3, peer.rx_byte);
    wr(`OFS_EVT, 8'h01);
    peer.drive_byte();
    repeat (10) @(posedge sys_clk);
    rdc("overflow set", `OFS_CTRL, 8'h64);
    rdc("first byte kept", `OFS_BUF, 8'h5A);
    chk("wake pulses", 2, wakes);
    sel_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("output floats", 0, sdo_oe);
    wr(`OFS_CTRL, 8'h00);
    wr(`OFS_CTRL, 8'h25);
    repeat (4) @(posedge sys_clk);
    chk("free slave drives", 1, sdo_oe);
    $display("test slave done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_master();
    t_rates();
    t_slave();
    complete_run();
  end

  // The whole run needs about 1300 clocks; this limit leaves a wide margin
  initial begin
    #(50 * 20000);
    errors++;
    complete_run();
  end
endmodule
